/* File: rtl/flash_self_access.sv */
// Self-access controller for on-chip program flash: registers, unlock, sequencer.
// Assumes one instruction cycle per ref_clk cycle and a flash array on array_* ports.
`timescale 1ns/1ps
`include "flash_self_map.svh"
module flash_self_access
  import flash_self_pkg::*;
#(
  parameter int PROG_CYCLES = `FS_PROG_CYCLES
) (
  input  wire logic                  ref_clk,
  input  wire logic                  resetn,
  input  wire logic                  por_event,
  input  wire sfr_req_s              sfr_req,
  output logic      [7:0]            sfr_rdata,
  output logic                       core_nop_force,
  output logic                       core_stall,
  input  wire logic                  read_protect,
  input  wire logic [1:0]            self_write_guard,
  input  wire logic                  prog_bulk_erase,
  input  wire logic                  prog_access,
  output logic                       prog_allow_ext,
  output array_cmd_s                 array_cmd,
  input  wire logic [`FS_WORD_W-1:0] array_rdata
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  localparam int CNT_W = $clog2(PROG_CYCLES + 1);
  localparam logic [CNT_W-1:0] PROG_LAST = CNT_W'(PROG_CYCLES - 1);

  seq_state_e            state_reg, state_next;
  logic [`FS_WORD_W-1:0] data_reg;
  logic [`FS_ADDR_W-1:0] addr_reg;
  logic                  rd_reg, wr_reg, allow_reg, abort_reg;
  logic                  free_reg, latch_only_load_reg, config_space_select_reg;
  logic [1:0]            key_reg;
  logic [CNT_W-1:0]      cnt_reg;
  logic [7:0]            rdata_reg;
  logic                  nop_reg, stall_reg, stall_out_reg, ext_reg;
  logic                  cp_latched_reg;
  array_cmd_s            cmd_reg;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire wr_ctrl   = sfr_req.wr && sfr_req.addr == `FS_REG_CTRL;
  wire wr_key    = sfr_req.wr && sfr_req.addr == `FS_REG_KEY;
  wire wr_datl   = sfr_req.wr && sfr_req.addr == `FS_REG_DATL;
  wire wr_dath   = sfr_req.wr && sfr_req.addr == `FS_REG_DATH;
  wire wr_adrl   = sfr_req.wr && sfr_req.addr == `FS_REG_ADRL;
  wire wr_adrh   = sfr_req.wr && sfr_req.addr == `FS_REG_ADRH;
  wire idle      = state_reg == ST_IDLE;
  wire rd_set    = wr_ctrl && sfr_req.wdata[`FS_CTRL_RD] && idle;
  wire wr_set    = wr_ctrl && sfr_req.wdata[`FS_CTRL_WR] && idle;
  // Key must be exactly 55h then AAh with no other access between
  wire key_ok    = key_reg == 2'd2;
  // Guard 11 leaves everything writable; 10 and 01 protect the low part in steps, 00 protects all of it
  wire [1:0] top2 = addr_reg[`FS_ADDR_W-2 -: 2];
  wire guarded   = (self_write_guard == 2'b11) ? 1'b0 :
                   (self_write_guard == 2'b10) ? (top2 == 2'b00) :
                   (self_write_guard == 2'b01) ? (top2 != 2'b11) : 1'b1;
  // Start only with key, allow and outside guard; config space not modelled
  wire go        = wr_set && key_ok && allow_reg && !config_space_select_reg && !guarded;
  wire go_latch  = go && latch_only_load_reg && !free_reg;
  wire go_long   = go && !go_latch;
  wire op_done   = state_reg == ST_BUSY && cnt_reg == PROG_LAST;
  // The trigger word itself enters its latch, also for the final row program
  wire go_load   = go && !free_reg;

  logic [`FS_WORD_W-1:0] latch_word;
  flash_latch_bank #(
    .WORDS (`FS_ROW_WORDS),
    .IDX_W (`FS_LATCH_IDX_W)
  ) u_latch (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .load    (go_load),
    .clear   (op_done),
    .idx     (addr_reg[`FS_LATCH_IDX_W-1:0]),
    .wdata   (data_reg),
    .rd_idx  (cnt_reg[`FS_LATCH_IDX_W-1:0]),
    .rd_word (latch_word)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (rd_set && !config_space_select_reg) state_next = ST_RD1;
        else if (go) state_next = ST_NOP1;
      end
      ST_RD1:  state_next = ST_RD2;
      ST_RD2:  state_next = ST_IDLE;
      ST_NOP1: state_next = ST_NOP2;
      ST_NOP2: state_next = stall_reg ? ST_BUSY : ST_IDLE;
      ST_BUSY: state_next = op_done ? ST_IDLE : ST_BUSY;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= (state_reg == ST_BUSY && !op_done) ? cnt_reg + CNT_W'(1) : '0;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rd_reg   <= 1'b0;
      wr_reg   <= 1'b0;
      free_reg <= 1'b0;
      latch_only_load_reg <= 1'b0;
      config_space_select_reg <= 1'b0;
      key_reg  <= 2'd0;
    end else begin
      // Software can only set start bits; hardware clears them at the end
      if (rd_set && !config_space_select_reg) rd_reg <= 1'b1;
      else if (state_reg == ST_RD2) rd_reg <= 1'b0;
      if (go) wr_reg <= 1'b1;
      else if (op_done || (state_reg == ST_NOP2 && !stall_reg)) wr_reg <= 1'b0;
      if (wr_ctrl) begin
        free_reg <= sfr_req.wdata[`FS_CTRL_FREE];
        latch_only_load_reg <= sfr_req.wdata[`FS_CTRL_LATCH_ONLY_LOAD];
        config_space_select_reg <= sfr_req.wdata[`FS_CTRL_CONFIG_SPACE_SELECT];
      end
      // Any access other than the next key step breaks the sequence
      if (wr_key && sfr_req.wdata == `FS_KEY_FIRST) key_reg <= 2'd1;
      else if (wr_key && sfr_req.wdata == `FS_KEY_SECOND && key_reg == 2'd1) key_reg <= 2'd2;
      else if (sfr_req.wr || sfr_req.rd) key_reg <= 2'd0;
    end
  end

  // Allow bit clears only at power-up, not on other resets
  always_ff @(posedge ref_clk) begin
    if (por_event) allow_reg <= 1'b0;
    else if (resetn && wr_ctrl) allow_reg <= sfr_req.wdata[`FS_CTRL_PROGRAM_ALLOW];
  end

  // Abort flag survives the reset that interrupted a write
  always_ff @(posedge ref_clk) begin
    if (por_event) begin
      abort_reg <= 1'b0;
    end else begin
      if (!resetn && wr_reg) abort_reg <= 1'b1;
      else if (resetn && wr_ctrl && !sfr_req.wdata[`FS_CTRL_WRITE_ABORT_FLAG]) abort_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Data and address pairs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      data_reg <= '0;
      addr_reg <= '0;
    end else begin
      // Read word lands one cycle after the ignored slot
      if (state_reg == ST_RD1) data_reg <= array_rdata;
      else if (wr_datl) data_reg[7:0] <= sfr_req.wdata;
      else if (wr_dath) data_reg[`FS_WORD_W-1:8] <= sfr_req.wdata[`FS_WORD_W-9:0];
      if (wr_adrl) addr_reg[7:0] <= sfr_req.wdata;
      if (wr_adrh) addr_reg[`FS_ADDR_W-1:8] <= sfr_req.wdata[`FS_ADDR_W-9:0];
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  logic [7:0] rd_mux;
  always_comb begin
    case (sfr_req.addr)
      `FS_REG_CTRL: rd_mux = {1'b0, config_space_select_reg, latch_only_load_reg, free_reg, abort_reg,
                              allow_reg, wr_reg, rd_reg};
      `FS_REG_KEY:  rd_mux = 8'h00;
      `FS_REG_DATL: rd_mux = data_reg[7:0];
      `FS_REG_DATH: rd_mux = {2'b00, data_reg[`FS_WORD_W-1:8]};
      `FS_REG_ADRL: rd_mux = addr_reg[7:0];
      `FS_REG_ADRH: rd_mux = {1'b0, addr_reg[`FS_ADDR_W-1:8]};
      default:      rd_mux = 8'h00;
    endcase
  end

  // Stall covers only erase and row program; latch loads never stall
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      rdata_reg <= 8'h00;
      nop_reg   <= 1'b0;
      stall_reg <= 1'b0;
      stall_out_reg <= 1'b0;
      ext_reg   <= 1'b0;
      cmd_reg   <= '0;
      cp_latched_reg <= 1'b0;
    end else begin
      rdata_reg <= rd_mux;
      // Forced slots: the two ignored read slots, or the two no-ops after a write start
      nop_reg   <= rd_set && !config_space_select_reg || go || state_reg == ST_NOP1 ||
                   state_reg == ST_RD1;
      if (go) stall_reg <= go_long;
      else if (op_done) stall_reg <= 1'b0;
      // Registered copy of the busy state so the stall output is a flop
      stall_out_reg <= state_next == ST_BUSY;
      // Protection holds until a programmer bulk erase or a reset
      if (prog_bulk_erase) cp_latched_reg <= 1'b0;
      else if (read_protect) cp_latched_reg <= 1'b1;
      ext_reg   <= prog_access && !(cp_latched_reg || read_protect);
      // Row select from upper bits; program does no implicit erase
      cmd_reg.req     <= (state_reg == ST_RD1) || (state_reg == ST_BUSY);
      cmd_reg.erase   <= state_reg == ST_BUSY && free_reg;
      cmd_reg.prog    <= state_reg == ST_BUSY && !free_reg;
      cmd_reg.addr    <= (state_reg == ST_BUSY) ?
                         {addr_reg[`FS_ADDR_W-1:`FS_LATCH_IDX_W],
                          cnt_reg[`FS_LATCH_IDX_W-1:0]} : addr_reg;
      cmd_reg.wdata   <= latch_word;
    end
  end

  assign sfr_rdata      = rdata_reg;
  assign core_nop_force = nop_reg;
  assign core_stall     = stall_out_reg;
  assign prog_allow_ext = ext_reg;
  assign array_cmd      = cmd_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  key_read_zero_a: assert property (sfr_req.rd && sfr_req.addr == `FS_REG_KEY
    |=> sfr_rdata == 8'h00) else $error("key register read nonzero");
  no_key_start_a: assert property (wr_set && !key_ok |=> state_reg == ST_IDLE)
    else $error("write started without key");
  no_allow_start_a: assert property (wr_set && !allow_reg |=> !wr_reg)
    else $error("write started without allow");
  read_timing_a: assert property (rd_set && !config_space_select_reg |=> state_reg == ST_RD1 ##1
    state_reg == ST_RD2 && data_reg == $past(array_rdata)) else $error("read word late");
  latch_no_stall_a: assert property (go_latch |-> ##1 nop_reg ##1 nop_reg ##1 !stall_reg)
    else $error("latch load stalled");
  long_stall_a: assert property (go_long |-> ##3 core_stall)
    else $error("erase did not stall");
  wr_clear_a: assert property ($fell(wr_reg) |-> $past(op_done) || $past(state_reg) == ST_NOP2)
    else $error("write bit cleared early");
  guard_block_a: assert property (wr_set && guarded |=> !wr_reg)
    else $error("guarded write started");
  ext_block_a: assert property (read_protect |=> !prog_allow_ext)
    else $error("programmer access under protect");

  read_cov_c:  cover property (state_reg == ST_RD2);
  latch_cov_c: cover property (go_latch);
  erase_cov_c: cover property (go_long && free_reg);
  prog_cov_c:  cover property (op_done && !free_reg);
endmodule : flash_self_access

/* File: include/flash_self_map.svh */
// Offsets, field positions, reset values and timing counts for flash self-access.
// Assumes it is included by the package and the design files.
`ifndef FLASH_SELF_MAP_SVH
`define FLASH_SELF_MAP_SVH
`define FS_ADDR_W        15
`define FS_WORD_W        14
`define FS_ROW_WORDS     32
`define FS_LATCH_IDX_W   5
`define FS_BLANK_WORD    14'h3FFF
`define FS_KEY_FIRST     8'h55
`define FS_KEY_SECOND    8'hAA
`define FS_REG_CTRL      3'h0
`define FS_REG_KEY       3'h1
`define FS_REG_DATL      3'h2
`define FS_REG_DATH      3'h3
`define FS_REG_ADRL      3'h4
`define FS_REG_ADRH      3'h5
`define FS_CTRL_RD       0
`define FS_CTRL_WR       1
`define FS_CTRL_PROGRAM_ALLOW     2
`define FS_CTRL_WRITE_ABORT_FLAG    3
`define FS_CTRL_FREE     4
`define FS_CTRL_LATCH_ONLY_LOAD     5
`define FS_CTRL_CONFIG_SPACE_SELECT     6
`define FS_PROG_TIME_US  2000
`define FS_CLK_MHZ       200
`define FS_PROG_CYCLES   (`FS_PROG_TIME_US * `FS_CLK_MHZ)
`endif

/* File: include/flash_self_pkg.sv */
// Types shared by the flash self-access controller and its latch bank.
// Assumes flash_self_map.svh is on the include path.
`include "flash_self_map.svh"
package flash_self_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RD1   = 3'b001,
    ST_RD2   = 3'b010,
    ST_NOP1  = 3'b011,
    ST_NOP2  = 3'b100,
    ST_BUSY  = 3'b101
  } seq_state_e;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } sfr_req_s;
  typedef struct packed {
    logic                 req;
    logic                 erase;
    logic                 prog;
    logic [`FS_ADDR_W-1:0] addr;
    logic [`FS_WORD_W-1:0] wdata;
  } array_cmd_s;
endpackage : flash_self_pkg

/* File: rtl/flash_latch_bank.sv */
// Bank of word-wide write latches for one flash row.
// Assumes loads and clears come from the sequencer on the same clock.
`timescale 1ns/1ps
`include "flash_self_map.svh"
module flash_latch_bank
  import flash_self_pkg::*;
#(
  parameter int WORDS = `FS_ROW_WORDS,
  parameter int IDX_W = `FS_LATCH_IDX_W
) (
  input  wire logic                  ref_clk,
  input  wire logic                  resetn,
  input  wire logic                  load,
  input  wire logic                  clear,
  input  wire logic [IDX_W-1:0]      idx,
  input  wire logic [`FS_WORD_W-1:0] wdata,
  input  wire logic [IDX_W-1:0]      rd_idx,
  output logic      [`FS_WORD_W-1:0] rd_word
);
  logic [`FS_WORD_W-1:0] latch_reg [WORDS];

  // Latches only fill through the data pair, never directly
  for (genvar g = 0; g < WORDS; g++) begin : g_latch
    always_ff @(posedge ref_clk) begin
      if (!resetn || clear) begin
        latch_reg[g] <= `FS_BLANK_WORD;
      end else if (load && idx == IDX_W'(g)) begin
        latch_reg[g] <= wdata;
      end
    end
  end

  assign rd_word = latch_reg[rd_idx];
endmodule : flash_latch_bank

/* File: bench/flash_array_model.sv */
// Behavioural program flash array answering the controller's array commands.
// Assumes one-cycle command pulses on ref_clk and a word address on array_cmd.addr.
`timescale 1ns/1ps
`include "flash_self_map.svh"
module flash_array_model
  import flash_self_pkg::*;
(
  input  wire logic                  ref_clk,
  input  wire array_cmd_s            array_cmd,
  output logic      [`FS_WORD_W-1:0] array_rdata
);
  // ----------------------------------------
  // Array contents
  // ----------------------------------------
  logic [`FS_WORD_W-1:0] mem [0:(1<<`FS_ADDR_W)-1];

  // Non-blank preload so erase and program effects are visible
  initial begin
    for (int i = 0; i < (1 << `FS_ADDR_W); i++) begin
      mem[i] = 14'(i) ^ 14'h2A5A;
    end
  end

  assign array_rdata = mem[array_cmd.addr];

  // Programming can only clear bits, so an unerased word shows it
  always @(posedge ref_clk) begin
    if (array_cmd.req && array_cmd.erase) begin
      for (int j = 0; j < `FS_ROW_WORDS; j++) begin
        mem[{array_cmd.addr[14:5], 5'(j)}] <= `FS_BLANK_WORD;
      end
    end else if (array_cmd.req && array_cmd.prog) begin
      mem[array_cmd.addr] <= mem[array_cmd.addr] & array_cmd.wdata;
    end
  end
endmodule : flash_array_model

/* File: bench/flash_self_access_test.sv */
// Self-checking bench for the flash self-access controller.
// Assumes the flash array model stands on the array ports.
`timescale 1ns/1ps
`include "flash_self_map.svh"
module flash_self_access_test
  import flash_self_pkg::*;
();
  // At least one full row of latch reads must fit in the programming time
  localparam int PROG = 40;
  logic                  ref_clk = 1'b0;
  logic                  resetn = 1'b0;
  logic                  por_event = 1'b1;
  sfr_req_s              sfr_req = '0;
  logic [7:0]            sfr_rdata;
  logic                  core_nop_force;
  logic                  core_stall;
  logic                  read_protect = 1'b0;
  logic [1:0]            self_write_guard = 2'b11;
  logic                  prog_bulk_erase = 1'b0;
  logic                  prog_access = 1'b0;
  logic                  prog_allow_ext;
  array_cmd_s            array_cmd;
  logic [`FS_WORD_W-1:0] array_rdata;
  int                    num_errors = 0;
  int                    checked = 0;
  int                    cycles = 0;

  always #2.5 ref_clk = ~ref_clk;

  flash_self_access #(.PROG_CYCLES(PROG)) u_dut (
    .ref_clk(ref_clk), .resetn(resetn), .por_event(por_event), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .core_nop_force(core_nop_force), .core_stall(core_stall),
    .read_protect(read_protect), .self_write_guard(self_write_guard),
    .prog_bulk_erase(prog_bulk_erase), .prog_access(prog_access),
    .prog_allow_ext(prog_allow_ext), .array_cmd(array_cmd), .array_rdata(array_rdata)
  );

  flash_array_model u_flash (
    .ref_clk(ref_clk), .array_cmd(array_cmd), .array_rdata(array_rdata)
  );

  // ----------------------------------------
  // Checks and access tasks
  // ----------------------------------------
  task automatic end_of_test();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t byte got %h exp %h", $time, got, exp);
    end
  endtask : chk_byte

  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t flag got %b exp %b", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_cnt(input int got, input int exp);
    checked++;
    if (got != exp) begin
      num_errors++;
      $display("[ERR] %0t stall count %0d exp %0d", $time, got, exp);
    end
  endtask : chk_cnt

  task automatic sfr_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    sfr_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    sfr_req <= '0;
  endtask : sfr_wr

  task automatic sfr_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    sfr_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    sfr_req <= '0;
    #1 d = sfr_rdata;
  endtask : sfr_rd

  task automatic set_addr(input logic [14:0] a);
    sfr_wr(`FS_REG_ADRL, a[7:0]);
    sfr_wr(`FS_REG_ADRH, {1'b0, a[14:8]});
  endtask : set_addr

  function automatic logic [13:0] pat(input logic [14:0] a);
    return a[13:0] ^ 14'h2A5A;
  endfunction : pat

  task automatic read_word(input logic [14:0] a, input logic [13:0] exp);
    logic [7:0] d;
    set_addr(a);
    sfr_wr(`FS_REG_CTRL, 8'h01);
    #1 chk_bit(core_nop_force, 1'b1);
    @(posedge ref_clk);
    #1 chk_bit(core_nop_force, 1'b1);
    sfr_rd(`FS_REG_DATL, d);
    chk_byte(d, exp[7:0]);
    sfr_rd(`FS_REG_DATH, d);
    chk_byte(d, {2'b00, exp[13:8]});
  endtask : read_word

  // Bench never raises interrupts, so launch never splits the key sequence
  task automatic launch(input logic [7:0] ctl, input bit key, input bit acc, input int exp);
    int n;
    n = 0;
    if (key) begin
      sfr_wr(`FS_REG_CTRL, ctl & 8'hFD);
      sfr_wr(`FS_REG_KEY, `FS_KEY_FIRST);
      sfr_wr(`FS_REG_KEY, `FS_KEY_SECOND);
    end
    sfr_wr(`FS_REG_CTRL, ctl);
    // No access in the two slots after the trigger
    #1 if (acc) chk_bit(core_nop_force, 1'b1);
    @(posedge ref_clk);
    #1 if (acc) chk_bit(core_nop_force, 1'b1);
    repeat (200) begin
      @(posedge ref_clk);
      #1 if (core_stall === 1'b1) n++; else break;
    end
    chk_cnt(n, exp);
  endtask : launch

  task automatic load(input logic [14:0] a, input logic [13:0] w, input logic [7:0] ctl,
                      input int exp);
    set_addr(a);
    sfr_wr(`FS_REG_DATL, w[7:0]);
    sfr_wr(`FS_REG_DATH, {2'b00, w[13:8]});
    launch(ctl, 1'b1, 1'b1, exp);
  endtask : load

  // ----------------------------------------
  // Timeout and main sequence
  // ----------------------------------------
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      num_errors++;
      end_of_test();
    end
  end

  initial begin
    logic [7:0] d;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    por_event <= 1'b0;
    sfr_rd(`FS_REG_CTRL, d);
    chk_byte(d, 8'h00);
    sfr_wr(`FS_REG_KEY, 8'h55);
    sfr_rd(`FS_REG_KEY, d);
    chk_byte(d, 8'h00);
    read_word(15'h3FFF, pat(15'h3FFF));
    sfr_rd(`FS_REG_CTRL, d);
    chk_byte(d & 8'h03, 8'h00);
    sfr_wr(`FS_REG_DATL, 8'hC3);
    sfr_rd(`FS_REG_DATL, d);
    chk_byte(d, 8'hC3);
    sfr_rd(`FS_REG_DATH, d);
    chk_byte(d, 8'(pat(15'h3FFF) >> 8));
    // Read start with config space selected does nothing
    sfr_wr(`FS_REG_CTRL, 8'h40);
    sfr_wr(`FS_REG_CTRL, 8'h41);
    #1 chk_bit(core_nop_force, 1'b0);
    sfr_rd(`FS_REG_DATL, d);
    chk_byte(d, 8'hC3);
    // Refused erase attempts leave the row intact
    set_addr(15'h0080);
    sfr_wr(`FS_REG_CTRL, 8'h14);
    launch(8'h16, 1'b0, 1'b0, 0);
    launch(8'h12, 1'b1, 1'b0, 0);
    sfr_wr(`FS_REG_CTRL, 8'h14);
    sfr_wr(`FS_REG_KEY, `FS_KEY_FIRST);
    sfr_rd(`FS_REG_DATL, d);
    sfr_wr(`FS_REG_KEY, `FS_KEY_SECOND);
    launch(8'h16, 1'b0, 1'b0, 0);
    @(posedge ref_clk) prog_access <= 1'b1;
    for (int g = 0; g < 3; g++) begin
      @(posedge ref_clk) self_write_guard <= 2'(g);
      launch(8'h16, 1'b1, 1'b0, 0);
      chk_bit(prog_allow_ext, 1'b1);
    end
    @(posedge ref_clk) self_write_guard <= 2'b11;
    read_word(15'h0080, pat(15'h0080));
    // Row erase under read protection
    @(posedge ref_clk) read_protect <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 chk_bit(prog_allow_ext, 1'b0);
    set_addr(15'h0045);
    launch(8'h16, 1'b1, 1'b1, PROG);
    read_word(15'h0040, 14'h3FFF);
    read_word(15'h005F, 14'h3FFF);
    read_word(15'h0060, pat(15'h0060));
    // Protection stays latched until a programmer bulk erase
    @(posedge ref_clk) read_protect <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 chk_bit(prog_allow_ext, 1'b0);
    @(posedge ref_clk) prog_bulk_erase <= 1'b1;
    @(posedge ref_clk) prog_bulk_erase <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1 chk_bit(prog_allow_ext, 1'b1);
    // Latch loads, then row program
    load(15'h0040, 14'h1234, 8'h26, 0);
    load(15'h0041, 14'h0F0F, 8'h26, 0);
    read_word(15'h0040, 14'h3FFF);
    load(15'h005F, 14'h2222, 8'h06, PROG);
    read_word(15'h0040, 14'h1234);
    read_word(15'h0041, 14'h0F0F);
    read_word(15'h005F, 14'h2222);
    read_word(15'h0050, 14'h3FFF);
    load(15'h0041, 14'h3CF0, 8'h06, PROG);
    read_word(15'h0041, 14'h0C00);
    read_word(15'h0040, 14'h1234);
    // Reset in the middle of an erase
    set_addr(15'h0100);
    sfr_wr(`FS_REG_CTRL, 8'h14);
    sfr_wr(`FS_REG_KEY, `FS_KEY_FIRST);
    sfr_wr(`FS_REG_KEY, `FS_KEY_SECOND);
    sfr_wr(`FS_REG_CTRL, 8'h16);
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    sfr_rd(`FS_REG_CTRL, d);
    chk_byte(d & 8'h0F, 8'h0C);
    sfr_wr(`FS_REG_CTRL, 8'h04);
    sfr_rd(`FS_REG_CTRL, d);
    chk_byte(d & 8'h0F, 8'h04);
    por_event <= 1'b1;
    @(posedge ref_clk);
    por_event <= 1'b0;
    sfr_rd(`FS_REG_CTRL, d);
    chk_byte(d & 8'h0F, 8'h00);
    end_of_test();
  end
endmodule : flash_self_access_test
